// file: bench/testbench.sv
// Self-checking bench for the triple timer block.
// Assumes the pin model drives count and trigger pins; inputs change at negedge.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic i_clk, i_reset, i_sfr_wr, gate_a, gate_b, cs_a, cs_b, run_a, run_b, clr_a, clr_b;
  logic int_a, int_b, fa, fb, fc, fx, prx, ptx;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] mode_a, mode_b;
  logic [3:0] fire = 4'h0;
  logic [3:0] pins;
  int err_count = 0, n_tests = 0, cycles = 0, rx_n = 0, tx_n = 0;

  tmr3_timers tmr3_timers_inst (.i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_timer_a_mode(mode_a),
    .i_timer_a_gate(gate_a), .i_timer_a_counter_select(cs_a), .i_timer_a_run(run_a),
    .i_timer_a_flag_clear(clr_a), .i_timer_b_mode(mode_b), .i_timer_b_gate(gate_b),
    .i_timer_b_counter_select(cs_b), .i_timer_b_run(run_b), .i_timer_b_flag_clear(clr_b),
    .i_ext_interrupt_pin_a(int_a), .i_ext_interrupt_pin_b(int_b),
    .i_timer_a_count_pin(pins[0]), .i_timer_b_count_pin(pins[1]),
    .i_timer_c_count_pin(pins[2]), .i_timer_c_trigger_pin(pins[3]),
    .o_timer_a_overflow_flag(fa), .o_timer_b_overflow_flag(fb), .o_timer_c_overflow_flag(fc),
    .o_timer_c_external_flag(fx), .o_serial_rx_clock_pulse(prx), .o_serial_tx_clock_pulse(ptx));
  tmr3_pin_model tmr3_pin_model_inst (.i_clk(i_clk), .i_fire(fire), .o_pins(pins));

  // Free-running core clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Hang guard and serial pulse tally
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    rx_n <= rx_n + int'(prx);
    tx_n <= tx_n + int'(ptx);
    if (cycles == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    addr = a;
    wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_clk);
    i_sfr_wr = 1'b0;
  endtask

  // Registered read: data of the address shows one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_clk);
    addr = a;
    @(negedge i_clk);
    v = rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  // One falling edge on the chosen pin, then time to be counted
  task automatic pulse(input int k);
    @(negedge i_clk);
    fire[k] = 1'b1;
    @(negedge i_clk);
    fire[k] = 1'b0;
    tick(8);
  endtask

  task automatic clr();
    clr_a = 1'b1;
    clr_b = 1'b1;
    tick(1);
    clr_a = 1'b0;
    clr_b = 1'b0;
    tick(1);
  endtask

  task automatic t_ab();
    int k;
    logic [7:0] v;
    rc(8'hc8, 8'h00);
    wr(8'h90, 8'h5a);
    rc(8'h90, 8'h00);
    {mode_a, gate_a, int_a} = 4'h6;
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'hff);
    run_a = 1'b1;
    tick(30);
    rc(8'h8a, 8'hfe);
    rc(8'h8c, 8'hff);
    int_a = 1'b1;
    for (k = 0; k < 40 && fa !== 1'b1; k++)
      tick(1);
    run_a = 1'b0;
    chk({7'h0, fa}, 8'h01);
    chk({7'h0, k > 12 && k < 29}, 8'h01);
    rc(8'h8a, 8'h00);
    clr();
    chk({7'h0, fa}, 8'h00);
    {mode_a, gate_a, cs_a} = 4'h1;
    wr(8'h8a, 8'h3f);
    wr(8'h8c, 8'hff);
    run_a = 1'b1;
    pulse(0);
    chk({7'h0, fa}, 8'h01);
    rc(8'h8c, 8'h00);
    rd(8'h8a, v);
    chk({3'h0, v[4:0]}, 8'h00);
    mode_a = 2'h1;
    wr(8'h8a, 8'h10);
    repeat (3) pulse(0);
    rc(8'h8a, 8'h13);
    clr();
    mode_a = 2'h2;
    wr(8'h8c, 8'h80);
    wr(8'h8a, 8'hff);
    pulse(0);
    chk({7'h0, fa}, 8'h01);
    rc(8'h8a, 8'h80);
    rc(8'h8c, 8'h80);
    $display("timer a tests done");
  endtask

  task automatic t_split();
    int k;
    logic [7:0] v;
    {run_a, mode_a, mode_b} = 5'h0f;
    clr();
    wr(8'h8b, 8'h55);
    wr(8'h8c, 8'hff);
    run_b = 1'b1;
    for (k = 0; k < 30 && fb !== 1'b1; k++)
      tick(1);
    chk({6'h0, fb, fa}, 8'h02);
    rc(8'h8b, 8'h55);
    mode_b = 2'h1;
    tick(30);
    rd(8'h8b, v);
    chk({7'h0, v != 8'h55}, 8'h01);
    {mode_a, mode_b, cs_b, gate_b, int_b} = 7'h56;
    clr();
    wr(8'h8b, 8'hff);
    tx_n = 0;
    pulse(1);
    chk(8'(tx_n), 8'h00);
    int_b = 1'b1;
    pulse(1);
    chk(8'(tx_n), 8'h01);
    chk({7'h0, fb}, 8'h01);
    run_b = 1'b0;
    $display("split tests done");
  endtask

  task automatic t_c();
    wr(8'hca, 8'h12);
    wr(8'hcb, 8'h34);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h02);
    pulse(2);
    rc(8'hcc, 8'hff);
    wr(8'hc8, 8'h06);
    pulse(2);
    chk({7'h0, fc}, 8'h01);
    rc(8'hcc, 8'h12);
    rc(8'hcd, 8'h34);
    wr(8'hc8, 8'h0e);
    wr(8'hcc, 8'h00);
    chk({7'h0, fc}, 8'h00);
    pulse(3);
    chk({7'h0, fx}, 8'h01);
    rc(8'hcc, 8'h12);
    wr(8'hc8, 8'h07);
    wr(8'hcc, 8'h78);
    wr(8'hcd, 8'h56);
    chk({7'h0, fx}, 8'h00);
    pulse(3);
    chk({7'h0, fx}, 8'h00);
    rc(8'hca, 8'h12);
    wr(8'hc8, 8'h0f);
    pulse(3);
    chk({7'h0, fx}, 8'h01);
    rc(8'hca, 8'h78);
    rc(8'hcb, 8'h56);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    pulse(2);
    chk({7'h0, fc}, 8'h01);
    rc(8'hcc, 8'h00);
    $display("timer c tests done");
  endtask

  task automatic t_baud();
    wr(8'hc8, 8'h37);
    wr(8'hcc, 8'hff);
    wr(8'hcd, 8'hff);
    rx_n = 0;
    tx_n = 0;
    pulse(2);
    chk({7'h0, fc}, 8'h00);
    rc(8'hcc, 8'h78);
    chk({rx_n[3:0], tx_n[3:0]}, 8'h11);
    wr(8'hc8, 8'h3f);
    wr(8'hcc, 8'h11);
    pulse(3);
    chk({7'h0, fx}, 8'h01);
    rc(8'hcc, 8'h11);
    $display("baud tests done");
  endtask

  initial
  begin
    {i_sfr_wr, gate_a, gate_b, cs_a, cs_b, run_a, run_b, clr_a, clr_b} = 9'h000;
    {addr, wdata, mode_a, mode_b, int_a, int_b} = 22'h000000;
    i_reset = 1'b1;
    tick(6);
    i_reset = 1'b0;
    t_ab();
    t_split();
    t_c();
    t_baud();
    report_and_stop();
  end
endmodule

`default_nettype wire

// file: bench/tmr3_checker.sv
// Port-level assertions for the triple timer block.
// Assumes one clock domain; bound to tmr3_timers after the module.
`timescale 1ns/100ps
`default_nettype none

module tmr3_checker
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [1:0] i_timer_a_mode,
  input wire logic i_timer_a_flag_clear,
  input wire logic i_timer_b_flag_clear,
  input wire logic i_timer_c_trigger_pin,
  input wire logic o_timer_a_overflow_flag,
  input wire logic o_timer_b_overflow_flag,
  input wire logic o_timer_c_overflow_flag,
  input wire logic o_timer_c_external_flag,
  input wire logic o_serial_rx_clock_pulse,
  input wire logic o_serial_tx_clock_pulse
);
  logic wr_ctl, clr7, clr6, set6, set7, clk_sel, tx_sel, ext_en;
  logic [3:0] trig_age;

  // Software writes to the timer C control bits
  assign wr_ctl = i_sfr_wr && (i_sfr_addr == 8'hc8);
  assign clr7 = wr_ctl && !i_sfr_wdata[7];
  assign clr6 = wr_ctl && !i_sfr_wdata[6];
  assign set7 = wr_ctl && i_sfr_wdata[7];
  assign set6 = wr_ctl && i_sfr_wdata[6];

  // Shadow of bits that only software changes
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      clk_sel <= 1'b0;
      tx_sel <= 1'b0;
      ext_en <= 1'b0;
    end
    else if (wr_ctl)
    begin
      clk_sel <= i_sfr_wdata[5] | i_sfr_wdata[4];
      tx_sel <= i_sfr_wdata[4];
      ext_en <= i_sfr_wdata[3];
    end
  end

  // Cycles since the last trigger fall; saturates so it never wraps back
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      trig_age <= 4'hf;
    else if ($fell(i_timer_c_trigger_pin))
      trig_age <= 4'h0;
    else if (trig_age != 4'hf)
      trig_age <= trig_age + 4'h1;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  a_aflag_held:
    assert property ($fell(o_timer_a_overflow_flag) |->
      $past(i_timer_a_flag_clear) || $past(i_reset)) else $error("A flag fell unasked");
  a_bflag_held:
    assert property ($fell(o_timer_b_overflow_flag) |->
      $past(i_timer_b_flag_clear) || $past(i_reset)) else $error("B flag fell unasked");
  a_cflag_sw_clear:
    assert property ($fell(o_timer_c_overflow_flag) |->
      $past(clr7, 2) || $past(i_reset) || $past(i_reset, 2)) else $error("C flag fell unasked");
  a_xflag_sw_clear:
    assert property ($fell(o_timer_c_external_flag) |->
      $past(clr6, 2) || $past(i_reset) || $past(i_reset, 2)) else $error("ext flag fell unasked");
  a_cflag_quiet_baud:
    assert property ($rose(o_timer_c_overflow_flag) |-> !$past(clk_sel, 2) || $past(set7, 2))
    else $error("C flag set in baud use");
  a_trigger_cause:
    assert property ($rose(o_timer_c_external_flag) |->
      (trig_age < 4'h9 && ext_en) || $past(set6, 2)) else $error("ext flag without trigger");
  a_route_b_tx:
    assert property ($rose(o_timer_b_overflow_flag) && $past(i_timer_a_mode) != 2'h3
      && !$past(tx_sel) |-> o_serial_tx_clock_pulse) else $error("B overflow not on tx");
  a_tx_single_cycle:
    assert property (o_serial_tx_clock_pulse |=> !o_serial_tx_clock_pulse)
    else $error("tx pulse too long");

  c_ext_flag: cover property ($rose(o_timer_c_external_flag));
  c_rx_from_c: cover property (o_serial_rx_clock_pulse && clk_sel);
  c_split_b_flag: cover property ($rose(o_timer_b_overflow_flag) && i_timer_a_mode == 2'h3);
endmodule

bind tmr3_timers tmr3_checker tmr3_checker_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
  .i_sfr_wdata(i_sfr_wdata), .i_timer_a_mode(i_timer_a_mode),
  .i_timer_a_flag_clear(i_timer_a_flag_clear), .i_timer_b_flag_clear(i_timer_b_flag_clear),
  .i_timer_c_trigger_pin(i_timer_c_trigger_pin),
  .o_timer_a_overflow_flag(o_timer_a_overflow_flag),
  .o_timer_b_overflow_flag(o_timer_b_overflow_flag),
  .o_timer_c_overflow_flag(o_timer_c_overflow_flag),
  .o_timer_c_external_flag(o_timer_c_external_flag),
  .o_serial_rx_clock_pulse(o_serial_rx_clock_pulse),
  .o_serial_tx_clock_pulse(o_serial_tx_clock_pulse)
);

`default_nettype wire

// file: bench/tmr3_pin_model.sv
// Far-side model of the count and trigger pins of the timer block.
// Assumes requests change at the falling edge; pins idle high.
`timescale 1ns/100ps
`default_nettype none

module tmr3_pin_model
(
  input wire logic i_clk,
  input wire logic [3:0] i_fire,
  output logic [3:0] o_pins
);
  logic [1:0] low_cnt [4] = '{default: 2'h0};

  // One request gives one low pulse of three cycles, long enough for a synchroniser
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (i_fire[k])
        low_cnt[k] <= 2'h3;
      else if (low_cnt[k] != 2'h0)
        low_cnt[k] <= low_cnt[k] - 2'h1;
    end
  end

  // Pin is low only inside a pulse
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      o_pins[k] = (low_cnt[k] == 2'h0);
  end
endmodule

`default_nettype wire

// file: design/tmr3_fall_detect.sv
// Falling edge detector for an external count or trigger pin.
// Assumes the pin is sampled on i_clk; one pulse per detected edge.
`timescale 1ns/100ps
`default_nettype none

module tmr3_fall_detect
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_fall
);

  logic sync_first;
  logic sync_second;
  logic last_level;

  // Two-stage sampling, then one more stage for the edge compare
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sync_first <= 1'b1;
      sync_second <= 1'b1;
      last_level <= 1'b1;
    end
    else
    begin
      sync_first <= i_pin;
      sync_second <= sync_first;
      last_level <= sync_second;
    end
  end

  // High-to-low seen on the settled stages only
  assign o_fall = last_level & ~sync_second;

endmodule

`default_nettype wire

// file: design/tmr3_pkg.sv
// Types shared by the triple timer/counter block.
// Assumes the constants of tmr3_regs.svh for all numeric values.
package tmr3_pkg;

  // Function of timer C as chosen by its control register
  typedef enum logic [1:0] {
    TMR3_C_OFF,
    TMR3_C_RELOAD,
    TMR3_C_CAPTURE,
    TMR3_C_BAUD
  } tmr3_c_func_t;

endpackage

// file: design/tmr3_regs.svh
// Register addresses, control bit positions, reset values and counts
// of the triple timer/counter block.
// Assumes an 8-bit special function register space of the core.
`ifndef TMR3_REGS_SVH
`define TMR3_REGS_SVH

// Special function register addresses
`define TMR3_ADDR_A_LO 8'h8a
`define TMR3_ADDR_B_LO 8'h8b
`define TMR3_ADDR_A_HI 8'h8c
`define TMR3_ADDR_B_HI 8'h8d
`define TMR3_ADDR_C_CTRL 8'hc8
`define TMR3_ADDR_C_CAPREL_LO 8'hca
`define TMR3_ADDR_C_CAPREL_HI 8'hcb
`define TMR3_ADDR_C_LO 8'hcc
`define TMR3_ADDR_C_HI 8'hcd

// Timer C control bit positions
`define TMR3_C_OVF_BIT 7
`define TMR3_C_EXT_FLAG_BIT 6
`define TMR3_C_RX_CLK_BIT 5
`define TMR3_C_TX_CLK_BIT 4
`define TMR3_C_EXT_EN_BIT 3
`define TMR3_C_RUN_BIT 2
`define TMR3_C_CNT_SEL_BIT 1
`define TMR3_C_CAP_SEL_BIT 0

// Reset values
`define TMR3_C_CTRL_RESET 8'h00
`define TMR3_COUNT_RESET 8'h00
`define TMR3_UNMAPPED_READ 8'h00

// Timer A and B mode field codes
`define TMR3_MODE_PRESCALE 2'h0
`define TMR3_MODE_FULL16 2'h1
`define TMR3_MODE_RELOAD8 2'h2
`define TMR3_MODE_SPLIT 2'h3

// Machine cycle of twelve core clocks
`define TMR3_MC_LAST 4'hb

`endif

// file: design/tmr3_timers.sv
// Three timer/counters of an 8052-style core: timers A, B and C.
// Assumes a core register port with single-cycle write strobes and
// mode, run and flag-clear controls of timers A and B from outside.
`timescale 1ns/100ps
`default_nettype none

`include "tmr3_regs.svh"

// Overview of operation
// - Prescaled mode: high byte plus five low bits
// - Prescaled rollover sets that timer's overflow flag
// - Count while run and (gate off or pin high)
// - Starting a timer leaves count bytes unchanged
// - Sixteen-bit mode counts whole pair, no prescaler
// - Auto-reload: low byte reloads from high byte
// - Timer B in mode three holds its count
// - Split mode: A high byte uses B controls
// - With A split, B mode three stops B
// - Timer C function chosen by run, clocks, capture
// - C reload mode: rollover flags and reloads
// - C reload: trigger falling edge reloads, flags
// - C capture: trigger edge copies count, flags
// - C capture: overflow flags without reloading
// - C overflow flag unless serial clocks chosen
// - Baud mode: external flag still settable
// - Clock selects route C or B overflows
// - External enable low ignores trigger pin
// - C counter select: pin or machine cycles
// - Serial clock use forces C auto-reload
// - C run bit starts and stops timer C
// - Mode field: prescale, 16-bit, reload8, split
// - A/B flags clear when service routine entered
// - A/B counter select: pin or machine cycles
module tmr3_timers
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [1:0] i_timer_a_mode,
  input wire logic i_timer_a_gate,
  input wire logic i_timer_a_counter_select,
  input wire logic i_timer_a_run,
  input wire logic i_timer_a_flag_clear,
  input wire logic [1:0] i_timer_b_mode,
  input wire logic i_timer_b_gate,
  input wire logic i_timer_b_counter_select,
  input wire logic i_timer_b_run,
  input wire logic i_timer_b_flag_clear,
  input wire logic i_ext_interrupt_pin_a,
  input wire logic i_ext_interrupt_pin_b,
  input wire logic i_timer_a_count_pin,
  input wire logic i_timer_b_count_pin,
  input wire logic i_timer_c_count_pin,
  input wire logic i_timer_c_trigger_pin,
  output logic o_timer_a_overflow_flag,
  output logic o_timer_b_overflow_flag,
  output logic o_timer_c_overflow_flag,
  output logic o_timer_c_external_flag,
  output logic o_serial_rx_clock_pulse,
  output logic o_serial_tx_clock_pulse
);

  logic [3:0] mc_count;
  logic mc_tick;
  logic a_pin_fall;
  logic b_pin_fall;
  logic c_pin_fall;
  logic c_trig_fall;
  logic [7:0] timer_a_count_low;
  logic [7:0] timer_a_count_high;
  logic [7:0] timer_b_count_low;
  logic [7:0] timer_b_count_high;
  logic [7:0] timer_c_count_low;
  logic [7:0] timer_c_count_high;
  logic [7:0] timer_c_capreload_low;
  logic [7:0] timer_c_capreload_high;
  logic [7:0] timer_c_control;
  logic [7:0] next_a_lo;
  logic [7:0] next_a_hi;
  logic [7:0] next_b_lo;
  logic [7:0] next_b_hi;
  logic [15:0] next_c_count;
  logic [15:0] next_c_caprel;
  logic a_split;
  logic a_inc;
  logic a_hi_inc;
  logic b_inc;
  logic c_inc;
  logic a_ovf;
  logic a_hi_ovf;
  logic b_ovf;
  logic c_ovf;
  logic c_trig;
  logic c_ext_set;
  logic c_baud;
  tmr3_pkg::tmr3_c_func_t c_func;

  // One step of a timer A/B register pair: {overflow, high, low}
  function automatic logic [16:0] ab_step(input logic [1:0] mode,
                                          input logic [7:0] hi,
                                          input logic [7:0] lo);
    logic [5:0] pre;
    logic [16:0] wide;
    logic [16:0] res;
    pre = {1'b0, lo[4:0]} + 6'h01;
    wide = {1'b0, hi, lo} + 17'h00001;
    res = {1'b0, hi, lo};
    case (mode)
      `TMR3_MODE_PRESCALE:
      begin
        // Upper three low bits are left as they are
        res[7:0] = {lo[7:5], pre[4:0]};
        res[15:8] = pre[5] ? hi + 8'h01 : hi;
        res[16] = (&hi) & (&lo[4:0]);
      end
      `TMR3_MODE_FULL16:
      begin
        res = wide;
      end
      `TMR3_MODE_RELOAD8:
      begin
        if (&lo)
        begin
          res = {1'b1, hi, hi};
        end
        else
        begin
          res[7:0] = lo + 8'h01;
        end
      end
      default:
      begin
        res = {1'b0, hi, lo};
      end
    endcase
    return res;
  endfunction

  // Machine cycle divider: one enable pulse every twelve clocks
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mc_count <= 4'h0;
      mc_tick <= 1'b0;
    end
    else
    begin
      mc_count <= (mc_count == `TMR3_MC_LAST) ? 4'h0 : mc_count + 4'h1;
      mc_tick <= (mc_count == `TMR3_MC_LAST);
    end
  end

  // Edge detectors for the four external pins
  tmr3_fall_detect u_a_pin
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_timer_a_count_pin),
    .o_fall(a_pin_fall)
  );

  tmr3_fall_detect u_b_pin
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_timer_b_count_pin),
    .o_fall(b_pin_fall)
  );

  tmr3_fall_detect u_c_pin
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_timer_c_count_pin),
    .o_fall(c_pin_fall)
  );

  tmr3_fall_detect u_c_trig
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_pin(i_timer_c_trigger_pin),
    .o_fall(c_trig_fall)
  );

  // Count enables of timers A and B
  always_comb
  begin
    a_split = (i_timer_a_mode == `TMR3_MODE_SPLIT);
    a_inc = i_timer_a_run & (~i_timer_a_gate | i_ext_interrupt_pin_a)
      & (i_timer_a_counter_select ? a_pin_fall : mc_tick);
    // Split high byte borrows B's run bit, machine cycles only
    a_hi_inc = a_split & i_timer_b_run & mc_tick;
    // With A split, B runs whenever it is out of its own mode three
    b_inc = (a_split ? 1'b1 : i_timer_b_run & (~i_timer_b_gate | i_ext_interrupt_pin_b))
      & (i_timer_b_mode != `TMR3_MODE_SPLIT)
      & (i_timer_b_counter_select ? b_pin_fall : mc_tick);
  end

  // Next values of timer A
  always_comb
  begin
    next_a_lo = timer_a_count_low;
    next_a_hi = timer_a_count_high;
    a_ovf = 1'b0;
    a_hi_ovf = 1'b0;
    if (a_split)
    begin
      if (a_inc)
      begin
        next_a_lo = timer_a_count_low + 8'h01;
        a_ovf = &timer_a_count_low;
      end
      if (a_hi_inc)
      begin
        next_a_hi = timer_a_count_high + 8'h01;
        a_hi_ovf = &timer_a_count_high;
      end
    end
    else if (a_inc)
    begin
      {a_ovf, next_a_hi, next_a_lo} = ab_step(i_timer_a_mode,
        timer_a_count_high, timer_a_count_low);
    end
  end

  // Next values of timer B; mode three never steps
  always_comb
  begin
    next_b_lo = timer_b_count_low;
    next_b_hi = timer_b_count_high;
    b_ovf = 1'b0;
    if (b_inc)
    begin
      {b_ovf, next_b_hi, next_b_lo} = ab_step(i_timer_b_mode,
        timer_b_count_high, timer_b_count_low);
    end
  end

  // Timer A count bytes; a software write beats a count step
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      timer_a_count_low <= `TMR3_COUNT_RESET;
      timer_a_count_high <= `TMR3_COUNT_RESET;
    end
    else
    begin
      // Run bit is only an enable, never a clear
      timer_a_count_low <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_A_LO) ?
        i_sfr_wdata : next_a_lo;
      timer_a_count_high <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_A_HI) ?
        i_sfr_wdata : next_a_hi;
    end
  end

  // Timer B count bytes
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      timer_b_count_low <= `TMR3_COUNT_RESET;
      timer_b_count_high <= `TMR3_COUNT_RESET;
    end
    else
    begin
      timer_b_count_low <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_B_LO) ?
        i_sfr_wdata : next_b_lo;
      timer_b_count_high <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_B_HI) ?
        i_sfr_wdata : next_b_hi;
    end
  end

  // Overflow flags of A and B; a set in the clearing cycle wins
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_timer_a_overflow_flag <= 1'b0;
      o_timer_b_overflow_flag <= 1'b0;
    end
    else
    begin
      o_timer_a_overflow_flag <= a_ovf | (o_timer_a_overflow_flag & ~i_timer_a_flag_clear);
      // Split A's high byte owns B's flag
      o_timer_b_overflow_flag <= (a_split ? a_hi_ovf : b_ovf)
        | (o_timer_b_overflow_flag & ~i_timer_b_flag_clear);
    end
  end

  // Timer C function decode
  always_comb
  begin
    c_baud = timer_c_control[`TMR3_C_RX_CLK_BIT] | timer_c_control[`TMR3_C_TX_CLK_BIT];
    if (!timer_c_control[`TMR3_C_RUN_BIT])
    begin
      c_func = tmr3_pkg::TMR3_C_OFF;
    end
    else if (c_baud)
    begin
      c_func = tmr3_pkg::TMR3_C_BAUD;
    end
    else if (timer_c_control[`TMR3_C_CAP_SEL_BIT])
    begin
      c_func = tmr3_pkg::TMR3_C_CAPTURE;
    end
    else
    begin
      c_func = tmr3_pkg::TMR3_C_RELOAD;
    end
  end

  // Timer C stepping, trigger handling and capture
  always_comb
  begin
    next_c_count = {timer_c_count_high, timer_c_count_low};
    next_c_caprel = {timer_c_capreload_high, timer_c_capreload_low};
    c_ovf = 1'b0;
    c_inc = (c_func != tmr3_pkg::TMR3_C_OFF)
      & (timer_c_control[`TMR3_C_CNT_SEL_BIT] ? c_pin_fall : mc_tick);
    // Trigger ignored unless enabled
    c_trig = timer_c_control[`TMR3_C_EXT_EN_BIT] & c_trig_fall;
    c_ext_set = c_trig;
    if (c_inc)
    begin
      if (&next_c_count)
      begin
        c_ovf = 1'b1;
        // Capture wraps to zero; reload and baud reload
        next_c_count = (c_func == tmr3_pkg::TMR3_C_CAPTURE) ? 16'h0000
          : next_c_caprel;
      end
      else
      begin
        next_c_count = next_c_count + 16'h0001;
      end
    end
    // Trigger acts on the count only while serial clocks are off
    if (c_trig && !c_baud)
    begin
      if (timer_c_control[`TMR3_C_CAP_SEL_BIT])
      begin
        next_c_caprel = {timer_c_count_high, timer_c_count_low};
      end
      else
      begin
        next_c_count = {timer_c_capreload_high, timer_c_capreload_low};
      end
    end
  end

  // Timer C count and capture/reload bytes; writes have priority
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      timer_c_count_low <= `TMR3_COUNT_RESET;
      timer_c_count_high <= `TMR3_COUNT_RESET;
      timer_c_capreload_low <= `TMR3_COUNT_RESET;
      timer_c_capreload_high <= `TMR3_COUNT_RESET;
    end
    else
    begin
      timer_c_count_low <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_C_LO) ?
        i_sfr_wdata : next_c_count[7:0];
      timer_c_count_high <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_C_HI) ?
        i_sfr_wdata : next_c_count[15:8];
      timer_c_capreload_low <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_C_CAPREL_LO) ?
        i_sfr_wdata : next_c_caprel[7:0];
      timer_c_capreload_high <= (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_C_CAPREL_HI) ?
        i_sfr_wdata : next_c_caprel[15:8];
    end
  end

  // Timer C control register; flags are sticky, set beats a clear
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      timer_c_control <= `TMR3_C_CTRL_RESET;
    end
    else
    begin
      if (i_sfr_wr && i_sfr_addr == `TMR3_ADDR_C_CTRL)
      begin
        timer_c_control <= i_sfr_wdata;
      end
      if (c_ovf && !c_baud)
      begin
        timer_c_control[`TMR3_C_OVF_BIT] <= 1'b1;
      end
      if (c_ext_set)
      begin
        timer_c_control[`TMR3_C_EXT_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // Flag outputs follow the control register one cycle later
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_timer_c_overflow_flag <= 1'b0;
      o_timer_c_external_flag <= 1'b0;
    end
    else
    begin
      o_timer_c_overflow_flag <= timer_c_control[`TMR3_C_OVF_BIT];
      o_timer_c_external_flag <= timer_c_control[`TMR3_C_EXT_FLAG_BIT];
    end
  end

  // Serial clock sources; B still overflows while A is split
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_serial_rx_clock_pulse <= 1'b0;
      o_serial_tx_clock_pulse <= 1'b0;
    end
    else
    begin
      o_serial_rx_clock_pulse <= timer_c_control[`TMR3_C_RX_CLK_BIT] ? c_ovf : b_ovf;
      o_serial_tx_clock_pulse <= timer_c_control[`TMR3_C_TX_CLK_BIT] ? c_ovf : b_ovf;
    end
  end

  // Read data registered one cycle after the address
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_sfr_rdata <= `TMR3_UNMAPPED_READ;
    end
    else if (i_sfr_addr == `TMR3_ADDR_A_LO)
    begin
      o_sfr_rdata <= timer_a_count_low;
    end
    else if (i_sfr_addr == `TMR3_ADDR_A_HI)
    begin
      o_sfr_rdata <= timer_a_count_high;
    end
    else if (i_sfr_addr == `TMR3_ADDR_B_LO)
    begin
      o_sfr_rdata <= timer_b_count_low;
    end
    else if (i_sfr_addr == `TMR3_ADDR_B_HI)
    begin
      o_sfr_rdata <= timer_b_count_high;
    end
    else if (i_sfr_addr == `TMR3_ADDR_C_CTRL)
    begin
      o_sfr_rdata <= timer_c_control;
    end
    else if (i_sfr_addr == `TMR3_ADDR_C_CAPREL_LO)
    begin
      o_sfr_rdata <= timer_c_capreload_low;
    end
    else if (i_sfr_addr == `TMR3_ADDR_C_CAPREL_HI)
    begin
      o_sfr_rdata <= timer_c_capreload_high;
    end
    else if (i_sfr_addr == `TMR3_ADDR_C_LO)
    begin
      o_sfr_rdata <= timer_c_count_low;
    end
    else if (i_sfr_addr == `TMR3_ADDR_C_HI)
    begin
      o_sfr_rdata <= timer_c_count_high;
    end
    else
    begin
      // Unmapped addresses read as zero
      o_sfr_rdata <= `TMR3_UNMAPPED_READ;
    end
  end

endmodule

`default_nettype wire
